// [pkg/pirq_pkg.sv]
// Package of register map, field layout and state type for the interrupt bank
package pirq_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// Byte offsets of the registers
	localparam logic [7:0] OFS_FLAGS3 = 8'h00;
	localparam logic [7:0] OFS_EN1 = 8'h04;
	localparam logic [7:0] OFS_EN2 = 8'h08;
	localparam logic [7:0] OFS_EN3 = 8'h0C;
	localparam logic [7:0] OFS_CTRL = 8'h10;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h18;
	localparam logic [7:0] OFS_IRQ_EN = 8'h1C;
	// Third request register bit positions
	localparam int B_SYNC2 = 7;
	localparam int B_BCOL2 = 6;
	localparam int B_RX2 = 5;
	localparam int B_TX2 = 4;
	localparam int B_TMR4 = 3;
	localparam int B_CC5 = 2;
	localparam int B_CC4 = 1;
	localparam int B_CC3 = 0;
	// First and second enable register special bits
	localparam int B_PSP = 7;
	localparam int B_EN2_RSVD = 4;
	localparam int B_EN2_UNIMP = 2;
	// Control register fields
	localparam int B_MASTER = 0;
	localparam int B_PRIO = 1;
	// Interrupt status fields
	localparam int B_IST_FLAG = 0;
	localparam int B_IST_RX = 1;
	localparam int B_IST_TX = 2;
	localparam int IST_W = 3;
	// Writable masks before variant gating
	localparam logic [7:0] EN1_MASK = 8'hFF;
	localparam logic [7:0] EN2_MASK = 8'hFB;
	localparam logic [7:0] EN3_MASK = 8'hFF;
	// Request mask of the second enable bank: reserved and unused bits out
	localparam logic [7:0] EN2_REQ_MASK = 8'hEB;
	// Sticky flags of the third request register
	localparam logic [7:0] STICKY_MASK = 8'hCF;
	// Reset values
	localparam logic [7:0] EN_RST = 8'h00;
	localparam logic [IST_W-1:0] IST_RST = 3'h0;
	// Package pin count codes
	localparam logic [1:0] PINS_64 = 2'h0;
	localparam logic [1:0] PINS_80 = 2'h1;
	localparam logic [1:0] PINS_100 = 2'h2;

	typedef struct packed {
		logic [7:0] en1;
		logic [7:0] en2;
		logic [7:0] en3;
		logic master;
		logic prio;
		logic [IST_W-1:0] ist;
		logic [IST_W-1:0] iena;
		logic ack;
		logic [DATA_W-1:0] rdata;
		logic irq;
		logic pirq;
		logic rx_prev;
		logic tx_prev;
	} pirq_state_t;

	typedef struct packed {
		logic flag;
	} pirq_cell_t;
endpackage : pirq_pkg

// [design/pirq_flag_cell.sv]
// Sticky request flag with set-over-clear priority
`timescale 1ns/1ps
`default_nettype none
module pirq_flag_cell (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic ce_in,
	input wire logic set_in,
	input wire logic clr_in,
	output logic flag_out
);
	import pirq_pkg::*;

	pirq_cell_t s_q;
	pirq_cell_t s_d;

	always_comb begin
		s_d = s_q;
		// Set wins so an event in the clearing cycle is kept
		if (set_in) begin
			s_d.flag = 1'b1;
		end else if (clr_in) begin
			s_d.flag = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			s_q <= '0;
		end else if (ce_in) begin
			s_q <= s_d;
		end
	end

	assign flag_out = s_q.flag;
endmodule : pirq_flag_cell
`default_nettype wire

// [design/pirq_bank.sv]
// Peripheral interrupt request flags and enable bank with Avalon-MM slave
//
// Overview of operation
// - Second sync serial done sets flag bit 7; only a zero write clears.
// - Second bus collision sets flag bit 6; stays until software clears.
// - Flag bit 5 read-only, follows second receive buffer holding data.
// - Flag bit 4 read-only, follows second transmit buffer being empty.
// - Timer 4 period match sets flag bit 3; stays until cleared.
// - Capture events of units five, four, three set bits 2..0; not in PWM.
// - Compare matches set the same three flags; sticky until cleared.
// - One enable bit per source; one enables, zero disables.
// - Without priority levels, master enable must be set for delivery.
// - First enable bank order: PSP, ADC, rx1, tx1, ssp1, cc1, t2, t1.
// - Second bank: osc fail, comparator, ethernet, collision1, t3, cc2.
// - Unimplemented bits ignore writes and read zero.
// - Third bank order: ssp2, bcol2, rx2, tx2, t4, cc5, cc4, cc3.
// - Bits 7..6 only on 100-pin, bits 5..4 on 80 and 100-pin.
// - PSP enable exists only on 100-pin parts in microcontroller mode.
// - Flags set regardless of their enable or global enable.
`timescale 1ns/1ps
`default_nettype none
module pirq_bank (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic ce_in,
	input wire logic [pirq_pkg::ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [pirq_pkg::DATA_W-1:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [pirq_pkg::DATA_W-1:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic [1:0] pin_count_in,
	input wire logic mcu_mode_in,
	input wire logic [7:0] req_flags1_in,
	input wire logic [7:0] req_flags2_in,
	input wire logic sync_serial2_done_in,
	input wire logic bus_collision2_in,
	input wire logic uart2_rx_full_in,
	input wire logic uart2_tx_empty_in,
	input wire logic timer4_match_in,
	input wire logic [2:0] capcomp_event_in,
	input wire logic [2:0] capcomp_pwm_mode_in,
	output logic [7:0] req_flags3_out,
	output logic periph_irq_out,
	output logic irq_out
);
	import pirq_pkg::*;

	pirq_state_t s_q;
	pirq_state_t s_d;
	logic [7:0] flags3;
	logic [7:0] set3;
	logic [7:0] clr3;
	logic [7:0] var3_mask;
	logic [7:0] en1_mask;
	logic has100;
	logic has80;
	logic req;
	logic wr_fire;
	logic wr_lane;
	logic [7:0] wbyte;
	logic [7:0] wr_en_sel;
	logic wr_flags;
	logic wr_ctrl;
	logic wr_iclr;
	logic wr_iena;
	logic rx_rise;
	logic tx_rise;
	logic sticky_set;
	logic any_pending;

	// Variant gating of optional sources
	assign has100 = (pin_count_in == PINS_100);
	assign has80 = (pin_count_in == PINS_80) || has100;
	always_comb begin
		var3_mask = 8'hFF;
		var3_mask[B_SYNC2] = has100;
		var3_mask[B_BCOL2] = has100;
		var3_mask[B_RX2] = has80;
		var3_mask[B_TX2] = has80;
		en1_mask = EN1_MASK;
		en1_mask[B_PSP] = has100 && mcu_mode_in;
	end

	// Bus decode; one wait state then the answer
	assign req = avs_read_in || avs_write_in;
	assign avs_waitrequest_out = req && !s_q.ack;
	assign wr_fire = avs_write_in && s_q.ack;
	assign wr_lane = wr_fire && avs_byteenable_in[0];
	assign wbyte = avs_writedata_in[7:0];
	assign wr_flags = wr_lane && (avs_address_in == OFS_FLAGS3);
	assign wr_ctrl = wr_lane && (avs_address_in == OFS_CTRL);
	assign wr_iclr = wr_lane && (avs_address_in == OFS_IRQ_CLR);
	assign wr_iena = wr_lane && (avs_address_in == OFS_IRQ_EN);
	always_comb begin
		wr_en_sel = 8'h00;
		wr_en_sel[0] = wr_lane && (avs_address_in == OFS_EN1);
		wr_en_sel[1] = wr_lane && (avs_address_in == OFS_EN2);
		wr_en_sel[2] = wr_lane && (avs_address_in == OFS_EN3);
	end

	// Flag set sources; no enable term, so polling works
	always_comb begin
		set3 = 8'h00;
		set3[B_SYNC2] = sync_serial2_done_in;
		set3[B_BCOL2] = bus_collision2_in;
		set3[B_TMR4] = timer4_match_in;
		// PWM mode leaves the flag alone
		set3[B_CC5] = capcomp_event_in[2] &&
			!capcomp_pwm_mode_in[2];
		set3[B_CC4] = capcomp_event_in[1] &&
			!capcomp_pwm_mode_in[1];
		set3[B_CC3] = capcomp_event_in[0] &&
			!capcomp_pwm_mode_in[0];
		set3 = set3 & var3_mask;
		// Writing one leaves a flag untouched; only zero clears
		clr3 = {8{wr_flags}} & ~wbyte;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_flag
			if (STICKY_MASK[gi]) begin : g_sticky
				pirq_flag_cell u_cell (
					.clk_in(clk_in),
					.rst_b_in(rst_b_in),
					.ce_in(ce_in),
					.set_in(set3[gi]),
					.clr_in(clr3[gi]),
					.flag_out(flags3[gi])
				);
			end else begin : g_level
				// Cleared by the serial port itself on buffer access
				assign flags3[gi] = (gi == B_RX2) ?
					(uart2_rx_full_in && var3_mask[gi]) :
					(uart2_tx_empty_in && var3_mask[gi]);
			end
		end
	endgenerate

	assign rx_rise = flags3[B_RX2] && !s_q.rx_prev;
	assign tx_rise = flags3[B_TX2] && !s_q.tx_prev;
	assign sticky_set = |(set3 & STICKY_MASK & ~flags3);

	// Pending request across all three banks
	assign any_pending = |(req_flags1_in & s_q.en1) ||
		|(req_flags2_in & s_q.en2 & EN2_REQ_MASK) ||
		|(flags3 & s_q.en3);

	always_comb begin
		s_d = s_q;
		s_d.ack = req && !s_q.ack;
		s_d.rx_prev = flags3[B_RX2];
		s_d.tx_prev = flags3[B_TX2];
		// Enable banks with per-bit write masks
		if (wr_en_sel[0]) begin
			s_d.en1 = wbyte & en1_mask;
		end
		if (wr_en_sel[1]) begin
			s_d.en2 = wbyte & EN2_MASK;
		end
		if (wr_en_sel[2]) begin
			s_d.en3 = wbyte & EN3_MASK & var3_mask;
		end
		if (wr_ctrl) begin
			s_d.master = wbyte[B_MASTER];
			s_d.prio = wbyte[B_PRIO];
		end
		if (wr_iena) begin
			s_d.iena = wbyte[IST_W-1:0];
		end
		if (wr_iclr) begin
			s_d.ist = s_q.ist & ~wbyte[IST_W-1:0];
		end
		// New events win over a clear in the same cycle
		s_d.ist[B_IST_FLAG] = s_d.ist[B_IST_FLAG] || sticky_set;
		s_d.ist[B_IST_RX] = s_d.ist[B_IST_RX] || rx_rise;
		s_d.ist[B_IST_TX] = s_d.ist[B_IST_TX] || tx_rise;
		s_d.irq = |(s_d.ist & s_d.iena);
		// Priority mode hands gating to the core; else master gates
		s_d.pirq = any_pending && (s_q.prio || s_q.master);
		// Read data captured in the wait cycle
		if (avs_read_in && !s_q.ack) begin
			s_d.rdata = '0;
			case (avs_address_in)
				OFS_FLAGS3: s_d.rdata[7:0] = flags3;
				OFS_EN1: s_d.rdata[7:0] = s_q.en1;
				OFS_EN2: s_d.rdata[7:0] = s_q.en2;
				OFS_EN3: s_d.rdata[7:0] = s_q.en3;
				OFS_CTRL: begin
					s_d.rdata[B_MASTER] = s_q.master;
					s_d.rdata[B_PRIO] = s_q.prio;
				end
				OFS_IRQ_STAT: s_d.rdata[IST_W-1:0] = s_q.ist;
				OFS_IRQ_EN: s_d.rdata[IST_W-1:0] = s_q.iena;
				default: s_d.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			s_q <= '0;
			s_q.en1 <= EN_RST;
			s_q.en2 <= EN_RST;
			s_q.en3 <= EN_RST;
			s_q.ist <= IST_RST;
			// A level already high at reset is not a new event
			s_q.rx_prev <= 1'b1;
			s_q.tx_prev <= 1'b1;
		end else if (ce_in) begin
			s_q <= s_d;
		end
	end

	assign avs_readdata_out = s_q.rdata;
	assign req_flags3_out = flags3;
	assign periph_irq_out = s_q.pirq;
	assign irq_out = s_q.irq;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_b_in);

	a_sync2_set: assert property (
		ce_in && sync_serial2_done_in && has100
		|=> flags3[B_SYNC2]
	) else $error("sync done flag not set");

	a_sync2_hold: assert property (
		flags3[B_SYNC2] && !(ce_in && clr3[B_SYNC2])
		|=> flags3[B_SYNC2]
	) else $error("sync done flag lost");

	a_bcol2_set: assert property (
		ce_in && bus_collision2_in && has100
		|=> flags3[B_BCOL2]
	) else $error("collision flag not set");

	a_bcol2_hold: assert property (
		flags3[B_BCOL2] && !(ce_in && clr3[B_BCOL2])
		&& $stable(pin_count_in)
		|=> flags3[B_BCOL2]
	) else $error("collision flag lost");

	a_rx_level: assert property (
		flags3[B_RX2] == (uart2_rx_full_in && has80)
	) else $error("rx flag wrong");

	a_tx_level: assert property (
		flags3[B_TX2] == (uart2_tx_empty_in && has80)
	) else $error("tx flag wrong");

	a_tmr4_set: assert property (
		ce_in && timer4_match_in
		|=> flags3[B_TMR4]
	) else $error("timer flag not set");

	a_tmr4_clear: assert property (
		ce_in && wr_flags && !wbyte[B_TMR4] && !timer4_match_in
		|=> !flags3[B_TMR4]
	) else $error("timer flag not cleared");

	a_pwm_block: assert property (
		ce_in && !flags3[B_CC3] && capcomp_pwm_mode_in[0] && !wr_flags
		##0 !(ce_in && capcomp_event_in[0] && !capcomp_pwm_mode_in[0])
		|=> !flags3[B_CC3]
	) else $error("pwm mode set flag");

	a_cc_set: assert property (
		ce_in && capcomp_event_in[2] && !capcomp_pwm_mode_in[2]
		|=> flags3[B_CC5] [*1]
	) else $error("compare flag not set");

	a_cc_hold: assert property (
		flags3[B_CC4] && !(ce_in && clr3[B_CC4])
		|=> flags3[B_CC4]
	) else $error("compare flag lost");

	a_unimp_zero: assert property (
		!s_q.en2[B_EN2_UNIMP]
	) else $error("unimplemented bit stored");

	a_rdata_upper: assert property (
		avs_readdata_out[DATA_W-1:8] == '0
	) else $error("upper read data bits set");

	a_psp_gate: assert property (
		ce_in && wr_en_sel[0] && !(has100 && mcu_mode_in)
		|=> !s_q.en1[B_PSP]
	) else $error("absent port enable stored");

	a_en3_variant: assert property (
		ce_in && wr_en_sel[2] && !has80
		|=> s_q.en3[7:4] == 4'h0
	) else $error("absent source enable stored");

	a_en_block: assert property (
		ce_in && s_q.en1 == 8'h00 && s_q.en3 == 8'h00
		&& (s_q.en2 & EN2_REQ_MASK) == 8'h00
		|=> !periph_irq_out
	) else $error("request with no source enabled");

	a_master_gate: assert property (
		ce_in && !s_q.prio && !s_q.master
		|=> !periph_irq_out
	) else $error("request without master");

	a_req_raise: assert property (
		ce_in && (s_q.prio || s_q.master) && |(flags3 & s_q.en3)
		|=> periph_irq_out
	) else $error("request not raised");

	a_ist_sticky: assert property (
		ce_in && sticky_set
		|=> s_q.ist[B_IST_FLAG]
	) else $error("new flag not reported");

	a_ce_freeze: assert property (
		!ce_in
		|=> $stable(s_q)
	) else $error("state moved while frozen");

	a_bus_answer: assert property (
		req && !s_q.ack && ce_in
		|=> !avs_waitrequest_out || !req
	) else $error("no bus answer");

	c_flag_poll: cover property (
		ce_in && wr_flags && !wbyte[B_TMR4] ##1 !flags3[B_TMR4]);
	c_irq_out: cover property (
		!irq_out ##1 irq_out);
	c_periph_req: cover property (
		!periph_irq_out ##1 periph_irq_out);
	c_set_vs_clr: cover property (
		ce_in && set3[B_TMR4] && clr3[B_TMR4]);
	c_pwm_event: cover property (
		ce_in && capcomp_event_in[0] && capcomp_pwm_mode_in[0]);
endmodule : pirq_bank
`default_nettype wire

// [sim/pirq_periph_model.sv]
// Peripheral model feeding event pulses and buffer levels to the bank
`timescale 1ns/1ps
`default_nettype none
module pirq_periph_model (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic [7:0] fire_in,
	input wire logic [3:0] uart_cmd_in,
	output logic [7:0] pulse_out,
	output logic rx_full_out,
	output logic tx_empty_out
);
	// Command bits: 0 byte arrives, 1 buffer read, 2 buffer written, 3 sent
	always_ff @(posedge clk_in) begin
		// One-cycle events, so the bank has to latch them itself
		pulse_out <= rst_b_in ? fire_in : 8'h00;
		if (!rst_b_in) begin
			rx_full_out <= 1'b0;
			tx_empty_out <= 1'b1;
		end else begin
			rx_full_out <= uart_cmd_in[0] | (rx_full_out & ~uart_cmd_in[1]);
			tx_empty_out <= uart_cmd_in[3] | (tx_empty_out & ~uart_cmd_in[2]);
		end
	end
endmodule : pirq_periph_model
`default_nettype wire

// [sim/test_pirq_bank.sv]
// Self-checking bench of the peripheral interrupt request bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
num_errors++; $display("mismatch %s exp %h got %h", nm, ex, got); end end
module test_pirq_bank;
	import pirq_pkg::*;
	logic clk_in = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] adr = 8'h00;
	logic rd_r = 1'b0;
	logic wr_r = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [3:0] be = 4'hF;
	logic [31:0] rdat;
	logic [31:0] rdata;
	logic wait_r;
	logic [1:0] pins = PINS_100;
	logic mcu = 1'b1;
	logic [7:0] fl1 = 8'h00;
	logic [7:0] fl2 = 8'h00;
	logic ce = 1'b1;
	logic [7:0] flg3;
	logic [7:0] fire = 8'h00;
	logic [3:0] ucmd = 4'h0;
	logic [2:0] pwm = 3'h0;
	logic [7:0] pulse;
	logic rxf;
	logic txe;
	logic pirq;
	logic irq;
	int num_errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	always #5 clk_in = ~clk_in;
	pirq_periph_model model (.clk_in(clk_in), .rst_b_in(rst_b),
		.fire_in(fire), .uart_cmd_in(ucmd), .pulse_out(pulse),
		.rx_full_out(rxf), .tx_empty_out(txe));
	pirq_bank dut (.clk_in(clk_in), .rst_b_in(rst_b), .ce_in(ce),
		.avs_address_in(adr), .avs_read_in(rd_r), .avs_write_in(wr_r),
		.avs_writedata_in(wdat), .avs_byteenable_in(be),
		.avs_readdata_out(rdat), .avs_waitrequest_out(wait_r),
		.pin_count_in(pins), .mcu_mode_in(mcu), .req_flags1_in(fl1),
		.req_flags2_in(fl2), .sync_serial2_done_in(pulse[7]),
		.bus_collision2_in(pulse[6]), .uart2_rx_full_in(rxf),
		.uart2_tx_empty_in(txe), .timer4_match_in(pulse[3]),
		.capcomp_event_in(pulse[2:0]), .capcomp_pwm_mode_in(pwm),
		.req_flags3_out(flg3), .periph_irq_out(pirq), .irq_out(irq));
	task automatic close_out;
		if (num_errors == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : close_out
	// Request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] b);
		adr <= a;
		wdat <= d;
		be <= b;
		rd_r <= ~w;
		wr_r <= w;
		do begin
			@(posedge clk_in);
		end while (wait_r !== 1'b0);
		rdata = rdat;
		rd_r <= 1'b0;
		wr_r <= 1'b0;
		@(posedge clk_in);
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask : wr
	task automatic rd(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		bus(1'b0, a, 32'h0, 4'hF);
		`CHK(nm, e, rdata)
	endtask : rd
	task automatic poke(input logic [7:0] f, input logic [3:0] u);
		fire <= f;
		ucmd <= u;
		@(posedge clk_in);
		fire <= 8'h00;
		ucmd <= 4'h0;
		repeat (2) @(posedge clk_in);
	endtask : poke
	// Two edges cover the registered request outputs
	task automatic irq_is(input logic pe, input logic ie);
		repeat (2) @(posedge clk_in);
		`CHK("periph_irq", pe, pirq)
		`CHK("irq", ie, irq)
	endtask : irq_is
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			close_out();
		end
	end
	initial begin
		repeat (12) @(posedge clk_in);
		rst_b <= 1'b1;
		@(posedge clk_in);
		rd("flags3", OFS_FLAGS3, 32'h10);
		for (int i = 1; i < 5; i++) rd("reset", 8'(i * 4), 32'h0);
		wr(OFS_EN1, 32'hFF);
		rd("en1", OFS_EN1, 32'hFF);
		wr(OFS_EN2, 32'hEF);
		rd("en2", OFS_EN2, 32'hEB);
		wr(OFS_EN3, 32'hFF);
		bus(1'b1, OFS_EN3, 32'h0, 4'h0);
		rd("en3", OFS_EN3, 32'hFF);
		rd("unmapped", 8'h20, 32'h0);
		wr(OFS_EN3, 32'h0);
		wr(OFS_EN1, 32'h01);
		fl1 <= 8'h01;
		irq_is(1'b0, 1'b0);
		wr(OFS_CTRL, 32'h1);
		irq_is(1'b1, 1'b0);
		wr(OFS_CTRL, 32'h2);
		irq_is(1'b1, 1'b0);
		wr(OFS_EN1, 32'h0);
		irq_is(1'b0, 1'b0);
		wr(OFS_EN2, 32'hFF);
		fl2 <= 8'h10;
		irq_is(1'b0, 1'b0);
		fl2 <= 8'h08;
		irq_is(1'b1, 1'b0);
		fl2 <= 8'h00;
		wr(OFS_EN2, 32'h0);
		fl1 <= 8'h00;
		wr(OFS_CTRL, 32'h1);
		poke(8'hCF, 4'h0);
		rd("flags3", OFS_FLAGS3, 32'hDF);
		`CHK("flags3_out", 8'hDF, flg3)
		irq_is(1'b0, 1'b0);
		wr(OFS_FLAGS3, 32'hF7);
		rd("flags3", OFS_FLAGS3, 32'hD7);
		wr(OFS_FLAGS3, 32'h0);
		rd("flags3", OFS_FLAGS3, 32'h10);
		poke(8'h00, 4'h1);
		wr(OFS_FLAGS3, 32'h0);
		rd("flags3", OFS_FLAGS3, 32'h30);
		poke(8'h00, 4'h2);
		rd("flags3", OFS_FLAGS3, 32'h10);
		poke(8'h00, 4'h4);
		rd("flags3", OFS_FLAGS3, 32'h00);
		pwm <= 3'b101;
		poke(8'h07, 4'h0);
		rd("flags3", OFS_FLAGS3, 32'h02);
		pwm <= 3'b000;
		wr(OFS_FLAGS3, 32'h0);
		wr(OFS_EN3, 32'h08);
		poke(8'h08, 4'h0);
		irq_is(1'b1, 1'b0);
		wr(OFS_FLAGS3, 32'h0);
		irq_is(1'b0, 1'b0);
		wr(OFS_IRQ_CLR, 32'h7);
		wr(OFS_IRQ_EN, 32'h1);
		poke(8'h01, 4'h0);
		irq_is(1'b0, 1'b1);
		rd("irq_stat", OFS_IRQ_STAT, 32'h1);
		wr(OFS_IRQ_EN, 32'h0);
		irq_is(1'b0, 1'b0);
		wr(OFS_IRQ_EN, 32'h1);
		wr(OFS_IRQ_CLR, 32'h1);
		irq_is(1'b0, 1'b0);
		rd("irq_clr", OFS_IRQ_CLR, 32'h0);
		pins <= PINS_64;
		wr(OFS_FLAGS3, 32'h0);
		poke(8'hC0, 4'h8);
		rd("flags3", OFS_FLAGS3, 32'h00);
		wr(OFS_EN3, 32'hFF);
		rd("en3", OFS_EN3, 32'h0F);
		pins <= PINS_80;
		wr(OFS_EN3, 32'hFF);
		rd("en3", OFS_EN3, 32'h3F);
		pins <= PINS_100;
		mcu <= 1'b0;
		wr(OFS_EN1, 32'hFF);
		rd("en1", OFS_EN1, 32'h7F);
		ce <= 1'b0;
		poke(8'h08, 4'h0);
		ce <= 1'b1;
		rd("ce_hold", OFS_FLAGS3, 32'h10);
		close_out();
	end
endmodule : test_pirq_bank
`default_nettype wire
